// *** rtl/amad_defs.vh ***
// register offsets, field positions, reset values and opcodes of the
// work-register move and arithmetic datapath; assumes a 32-bit AXI4-Lite bus
`ifndef AMAD_DEFS_VH
`define AMAD_DEFS_VH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define AMAD_OFS_CMD        8'h00
`define AMAD_OFS_WORK       8'h04
`define AMAD_OFS_FLAGS      8'h08
`define AMAD_OFS_STACK      8'h0C
`define AMAD_OFS_MADDR      8'h10
`define AMAD_OFS_MDATA      8'h14
`define AMAD_OFS_STATUS     8'h18

// ------------------------------------------------------------------
// command register fields
// ------------------------------------------------------------------
`define AMAD_CMD_OP_LSB     0
`define AMAD_CMD_OP_MSB     3
`define AMAD_CMD_DST_BIT    4
`define AMAD_CMD_OPND_LSB   8
`define AMAD_CMD_OPND_MSB   15

// ------------------------------------------------------------------
// flag byte layout
// ------------------------------------------------------------------
`define AMAD_FLG_ZERO       0
`define AMAD_FLG_CARRY      1
`define AMAD_FLG_HALF       2
`define AMAD_FLG_EXCESS     3

// ------------------------------------------------------------------
// status register fields
// ------------------------------------------------------------------
`define AMAD_STS_BUSY       0
`define AMAD_STS_BADOP      1

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define AMAD_RST_WORK       8'h00
`define AMAD_RST_FLAGS      4'h0
`define AMAD_RST_STACK      8'h00
`define AMAD_RST_MADDR      8'h00

// ------------------------------------------------------------------
// opcodes
// ------------------------------------------------------------------
`define AMAD_OP_IDX_STORE   4'h0
`define AMAD_OP_SWAP        4'h1
`define AMAD_OP_PUSH        4'h2
`define AMAD_OP_POP         4'h3
`define AMAD_OP_ADD_IMM     4'h4
`define AMAD_OP_ADD_MEM     4'h5
`define AMAD_OP_ADDC_MEM    4'h6
`define AMAD_OP_ADD_CARRY   4'h7
`define AMAD_OP_NEG_ADD     4'h8
`define AMAD_OP_SUB_IMM     4'h9
`define AMAD_OP_SUB_MEM     4'hA

// ------------------------------------------------------------------
// bus responses
// ------------------------------------------------------------------
`define AMAD_RESP_OKAY      2'h0
`define AMAD_RESP_SLVERR    2'h2

`endif

// *** rtl/amad_datapath.v ***
// work-register move and arithmetic datapath with its own data RAM
// assumes an AXI4-Lite master, one write and one read in flight at most
//
// Behaviour
// - indirect store writes work register where a RAM pointer points.
// - swap exchanges work register and memory byte, flags untouched.
// - push stores work register and flags at stack pointer, then adds 2.
// - pop lowers stack pointer by 2 then reloads work register and flags.
// - add immediate adds constant into work register, flags update.
// - add memory sums work register and byte into either operand.
// - add-with-carry sums both operands and carry into either operand.
// - carry-only add adds carry to work register or memory byte.
// - negated add negates destination, adds other operand into it.
// - subtract immediate adds two's complement of constant to work register.
// - subtract memory adds two's complement of byte to work register.
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`include "amad_defs.vh"

module amad_datapath #(
   parameter MEM_AW = 8
) (
   // clock and reset
   input  wire        mclk_in,
   input  wire        reset_in,
   // write address and data
   input  wire [7:0]  s_axi_awaddr_in,
   input  wire        s_axi_awvalid_in,
   output reg         s_axi_awready_out,
   input  wire [31:0] s_axi_wdata_in,
   input  wire [3:0]  s_axi_wstrb_in,
   input  wire        s_axi_wvalid_in,
   output reg         s_axi_wready_out,
   // write response
   output reg  [1:0]  s_axi_bresp_out,
   output reg         s_axi_bvalid_out,
   input  wire        s_axi_bready_in,
   // read address and data
   input  wire [7:0]  s_axi_araddr_in,
   input  wire        s_axi_arvalid_in,
   output reg         s_axi_arready_out,
   output reg  [31:0] s_axi_rdata_out,
   output reg  [1:0]  s_axi_rresp_out,
   output reg         s_axi_rvalid_out,
   input  wire        s_axi_rready_in,
   // datapath state
   output reg  [7:0]  work_register_out,
   output reg  [3:0]  flags_out,
   output reg  [7:0]  stack_pointer_out,
   output reg         busy_out
);

   localparam DEPTH = 1 << MEM_AW;

   reg [7:0]  mem [0:DEPTH-1];
   reg [7:0]  maddr_reg;
   reg [3:0]  op_reg;
   reg        dst_reg;
   reg [7:0]  opnd_reg;
   reg        badop_reg;
   reg        aw_got_reg;
   reg        w_got_reg;
   reg [7:0]  awaddr_reg;
   reg [31:0] wdata_reg;
   reg [3:0]  wstrb_reg;

   // ------------------------------------------------------------------
   // execution unit
   // ------------------------------------------------------------------
   reg [7:0] work_next;
   reg [3:0] flags_next;
   reg [7:0] stack_next;
   reg       we0;
   reg [7:0] wa0;
   reg [7:0] wd0;
   reg       we1;
   reg [7:0] wa1;
   reg [7:0] wd1;
   reg       arith;
   reg       do_sub;
   reg       to_mem;
   reg [7:0] xa;
   reg [7:0] xb;
   reg       cin;
   reg       bad;
   reg [8:0] full;
   reg [4:0] half;
   reg [7:0] res;
   reg       ovf;
   reg [7:0] mop;

   always @* begin
      work_next  = work_register_out;
      flags_next = flags_out;
      stack_next = stack_pointer_out;
      we0 = 1'b0;
      wa0 = opnd_reg;
      wd0 = work_register_out;
      we1 = 1'b0;
      wa1 = stack_pointer_out + 8'h01;
      wd1 = {4'h0, flags_out};
      arith  = 1'b1;
      do_sub = 1'b0;
      to_mem = 1'b0;
      xa  = work_register_out;
      xb  = 8'h00;
      cin = 1'b0;
      bad = 1'b0;
      mop = mem[opnd_reg];
      case (op_reg)
         `AMAD_OP_IDX_STORE: begin
            arith = 1'b0;
            we0   = 1'b1;
            wa0   = mop;
         end
         `AMAD_OP_SWAP: begin
            arith     = 1'b0;
            we0       = 1'b1;
            work_next = mop;
         end
         `AMAD_OP_PUSH: begin
            arith      = 1'b0;
            we0        = 1'b1;
            wa0        = stack_pointer_out;
            we1        = 1'b1;
            stack_next = stack_pointer_out + 8'h02;
         end
         `AMAD_OP_POP: begin
            arith      = 1'b0;
            stack_next = stack_pointer_out - 8'h02;
            work_next  = mem[stack_next];
            flags_next = mem[stack_pointer_out - 8'h01][3:0];
         end
         `AMAD_OP_ADD_IMM: begin
            xb = opnd_reg;
         end
         `AMAD_OP_ADD_MEM: begin
            xb     = mop;
            to_mem = dst_reg;
         end
         `AMAD_OP_ADDC_MEM: begin
            xb     = mop;
            cin    = flags_out[`AMAD_FLG_CARRY];
            to_mem = dst_reg;
         end
         `AMAD_OP_ADD_CARRY: begin
            xa     = dst_reg ? mop : work_register_out;
            cin    = flags_out[`AMAD_FLG_CARRY];
            to_mem = dst_reg;
         end
         `AMAD_OP_NEG_ADD: begin
            do_sub = 1'b1;
            xa     = dst_reg ? work_register_out : mop;
            xb     = dst_reg ? mop : work_register_out;
            to_mem = dst_reg;
         end
         `AMAD_OP_SUB_IMM: begin
            do_sub = 1'b1;
            xb     = opnd_reg;
         end
         `AMAD_OP_SUB_MEM: begin
            do_sub = 1'b1;
            xb     = mop;
         end
         default: begin
            arith = 1'b0;
            bad   = 1'b1;
         end
      endcase
      if (do_sub) begin
         full = {1'b0, xa} - {1'b0, xb};
         half = {1'b0, xa[3:0]} - {1'b0, xb[3:0]};
         ovf  = (xa[7] != xb[7]) && (full[7] != xa[7]);
      end else begin
         full = {1'b0, xa} + {1'b0, xb} + {8'h00, cin};
         half = {1'b0, xa[3:0]} + {1'b0, xb[3:0]} + {4'h0, cin};
         ovf  = (xa[7] == xb[7]) && (full[7] != xa[7]);
      end
      res = full[7:0];
      if (arith) begin
         flags_next[`AMAD_FLG_ZERO]   = (res == 8'h00);
         flags_next[`AMAD_FLG_CARRY]  = full[8];
         flags_next[`AMAD_FLG_HALF]   = half[4];
         flags_next[`AMAD_FLG_EXCESS] = ovf;
         if (to_mem) begin
            we0 = 1'b1;
            wd0 = res;
         end else begin
            work_next = res;
         end
      end
   end

   // ------------------------------------------------------------------
   // write channel
   // ------------------------------------------------------------------
   wire        wr_go  = aw_got_reg && w_got_reg && !s_axi_bvalid_out;
   wire [7:0]  wr_ofs = {awaddr_reg[7:2], 2'b00};
   wire        wr_hit = (wr_ofs <= `AMAD_OFS_STATUS);
   wire        wl0    = wr_go && wstrb_reg[0];

   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out  <= 1'b0;
         s_axi_bvalid_out  <= 1'b0;
         s_axi_bresp_out   <= `AMAD_RESP_OKAY;
         aw_got_reg        <= 1'b0;
         w_got_reg         <= 1'b0;
         awaddr_reg        <= 8'h00;
         wdata_reg         <= 32'h0000_0000;
         wstrb_reg         <= 4'h0;
      end else begin
         s_axi_awready_out <= !aw_got_reg && !s_axi_awready_out;
         s_axi_wready_out  <= !w_got_reg && !s_axi_wready_out;
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_got_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr_in;
            s_axi_awready_out <= 1'b0;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_got_reg <= 1'b1;
            wdata_reg <= s_axi_wdata_in;
            wstrb_reg <= s_axi_wstrb_in;
            s_axi_wready_out <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= wr_hit ? `AMAD_RESP_OKAY
                                       : `AMAD_RESP_SLVERR;
         end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
            aw_got_reg       <= 1'b0;
            w_got_reg        <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // datapath state and command issue
   // ------------------------------------------------------------------
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         work_register_out <= `AMAD_RST_WORK;
         flags_out         <= `AMAD_RST_FLAGS;
         stack_pointer_out <= `AMAD_RST_STACK;
         maddr_reg         <= `AMAD_RST_MADDR;
         busy_out          <= 1'b0;
         badop_reg         <= 1'b0;
         op_reg            <= 4'h0;
         dst_reg           <= 1'b0;
         opnd_reg          <= 8'h00;
      end else if (busy_out) begin
         work_register_out <= work_next;
         flags_out         <= flags_next;
         stack_pointer_out <= stack_next;
         badop_reg         <= bad;
         busy_out          <= 1'b0;
      end else if (wl0) begin
         case (wr_ofs)
            `AMAD_OFS_CMD: begin
               op_reg  <= wdata_reg[`AMAD_CMD_OP_MSB:`AMAD_CMD_OP_LSB];
               dst_reg <= wdata_reg[`AMAD_CMD_DST_BIT];
               if (wstrb_reg[1])
                  opnd_reg <= wdata_reg[`AMAD_CMD_OPND_MSB:`AMAD_CMD_OPND_LSB];
               busy_out <= 1'b1;
            end
            `AMAD_OFS_WORK:  work_register_out <= wdata_reg[7:0];
            `AMAD_OFS_FLAGS: flags_out         <= wdata_reg[3:0];
            `AMAD_OFS_STACK: stack_pointer_out <= wdata_reg[7:0];
            `AMAD_OFS_MADDR: maddr_reg         <= wdata_reg[7:0];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // data RAM, unreset
   // ------------------------------------------------------------------
   always @(posedge mclk_in) begin
      if (busy_out) begin
         if (we0)
            mem[wa0[MEM_AW-1:0]] <= wd0;
         if (we1)
            mem[wa1[MEM_AW-1:0]] <= wd1;
      end else if (wl0 && wr_ofs == `AMAD_OFS_MDATA) begin
         mem[maddr_reg[MEM_AW-1:0]] <= wdata_reg[7:0];
      end
   end

   // ------------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------------
   reg [31:0] rd_val;
   reg        rd_hit;
   wire [7:0] rd_ofs = {s_axi_araddr_in[7:2], 2'b00};

   always @* begin
      rd_hit = 1'b1;
      rd_val = 32'h0000_0000;
      case (rd_ofs)
         `AMAD_OFS_CMD:
            rd_val = {16'h0000, opnd_reg, 3'h0, dst_reg, op_reg};
         `AMAD_OFS_WORK:   rd_val = {24'h000000, work_register_out};
         `AMAD_OFS_FLAGS:  rd_val = {28'h0000000, flags_out};
         `AMAD_OFS_STACK:  rd_val = {24'h000000, stack_pointer_out};
         `AMAD_OFS_MADDR:  rd_val = {24'h000000, maddr_reg};
         `AMAD_OFS_MDATA:
            rd_val = {24'h000000, mem[maddr_reg[MEM_AW-1:0]]};
         `AMAD_OFS_STATUS: rd_val = {30'h00000000, badop_reg, busy_out};
         default:          rd_hit = 1'b0;
      endcase
   end

   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out  <= 1'b0;
         s_axi_rdata_out   <= 32'h0000_0000;
         s_axi_rresp_out   <= `AMAD_RESP_OKAY;
      end else begin
         s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
         if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rdata_out   <= rd_val;
            s_axi_rresp_out   <= rd_hit ? `AMAD_RESP_OKAY
                                        : `AMAD_RESP_SLVERR;
         end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
      end
   end

endmodule // amad_datapath

// *** verification/amad_datapath_asserts.sv ***
// checker for the datapath, watching the top ports only
// assumes one clock; bound onto amad_datapath below
module amad_datapath_chk (
   // clock and reset
   input wire        mclk_in,
   input wire        reset_in,
   // bus
   input wire [7:0]  s_axi_awaddr_in,
   input wire [31:0] s_axi_wdata_in,
   input wire        s_axi_wvalid_in,
   input wire        s_axi_wready_out,
   input wire        s_axi_arvalid_in,
   input wire        s_axi_arready_out,
   input wire        s_axi_rvalid_out,
   // datapath state
   input wire [7:0]  work_register_out,
   input wire [3:0]  flags_out,
   input wire [7:0]  stack_pointer_out,
   input wire        busy_out
);
   timeunit 1ns;
   timeprecision 1ns;
   reg  [15:0] cmd_reg;
   wire [3:0]  op   = cmd_reg[3:0];
   wire [7:0]  opnd = cmd_reg[15:8];
   wire [7:0]  wk   = work_register_out;
   wire [7:0]  ptr  = stack_pointer_out;

   // last command word written
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in)
         cmd_reg <= 16'h0000;
      else if (s_axi_wvalid_in && s_axi_wready_out && s_axi_awaddr_in == 8'h00)
         cmd_reg <= s_axi_wdata_in[15:0];
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   chk_store_keeps: assert property (
      busy_out && op == 4'h0 |=> $stable(flags_out) && $stable(wk))
      else $error("store altered work register or flags");
   chk_swap_flags: assert property (
      busy_out && op == 4'h1 |=> $stable(flags_out))
      else $error("swap altered flags");
   chk_push_ptr: assert property (
      busy_out && op == 4'h2 |=>
      ptr == $past(ptr) + 8'h02 && $stable(flags_out))
      else $error("push pointer or flags wrong");
   chk_pop_ptr: assert property (
      busy_out && op == 4'h3 |=> ptr == $past(ptr) - 8'h02)
      else $error("pop pointer wrong");
   chk_add_imm: assert property (
      busy_out && op == 4'h4 |=> wk == $past(wk) + opnd &&
      flags_out[1] == ({1'b0, $past(wk)} + {1'b0, opnd} > 9'h0FF))
      else $error("add immediate result wrong");
   chk_carry_add: assert property (
      busy_out && op == 4'h7 && !cmd_reg[4] |=>
      wk == $past(wk) + {7'h00, $past(flags_out[1])})
      else $error("carry add result wrong");
   chk_sub_imm: assert property (
      busy_out && op == 4'h9 |=> wk == $past(wk) - opnd)
      else $error("subtract immediate result wrong");
   chk_sub_borrow: assert property (
      busy_out && op == 4'h9 |=> flags_out[1] == ($past(wk) < opnd))
      else $error("subtract borrow wrong");
   chk_read_answer: assert property (
      s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read answer late");
   chk_busy_pulse: assert property (
      busy_out |=> !busy_out)
      else $error("busy held longer than one cycle");
endmodule // amad_datapath_chk

bind amad_datapath amad_datapath_chk u_chk (.mclk_in, .reset_in,
   .s_axi_awaddr_in, .s_axi_wdata_in, .s_axi_wvalid_in, .s_axi_wready_out,
   .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out,
   .work_register_out, .flags_out, .stack_pointer_out, .busy_out);

// *** verification/amad_axi_master.sv ***
// bus master model for the register port
// assumes one clock; tasks called from the bench top
module amad_axi_master (
   // clock
   input  wire         mclk_in,
   // requests
   output logic [7:0]  awaddr_out,
   output logic        awvalid_out,
   output logic [31:0] wdata_out,
   output logic        wvalid_out,
   output logic        bready_out,
   output logic [7:0]  araddr_out,
   output logic        arvalid_out,
   output logic        rready_out,
   // answers
   input  wire         awready_in,
   input  wire         wready_in,
   input  wire         bvalid_in,
   input  wire  [1:0]  bresp_in,
   input  wire         arready_in,
   input  wire         rvalid_in,
   input  wire  [31:0] rdata_in,
   input  wire  [1:0]  rresp_in
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {awaddr_out, awvalid_out, wdata_out, wvalid_out} = '0;
      {bready_out, araddr_out, arvalid_out, rready_out} = '0;
   end

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      @(posedge mclk_in);
      awaddr_out  <= a;
      wdata_out   <= d;
      awvalid_out <= 1'b1;
      wvalid_out  <= 1'b1;
      bready_out  <= 1'b1;
      do begin
         @(posedge mclk_in);
         if (awready_in && awvalid_out)
            awvalid_out <= 1'b0;
         if (wready_in && wvalid_out)
            wvalid_out <= 1'b0;
      end while (!bvalid_in);
      r = bresp_in;
      bready_out <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge mclk_in);
      araddr_out  <= a;
      arvalid_out <= 1'b1;
      rready_out  <= 1'b1;
      do begin
         @(posedge mclk_in);
         if (arready_in && arvalid_out)
            arvalid_out <= 1'b0;
      end while (!rvalid_in);
      d = rdata_in;
      r = rresp_in;
      rready_out <= 1'b0;
   endtask
endmodule // amad_axi_master

// *** verification/amad_datapath_tb.sv ***
// self-checking bench for the move and arithmetic datapath
// assumes the checker bound in and the bus model beside it
module amad_datapath_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk_in  = 1'b0;
   logic        reset_in = 1'b1;
   logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in, work_register_out;
   logic [7:0]  stack_pointer_out;
   logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rdat;
   logic [3:0]  s_axi_wstrb_in = 4'hF;
   logic [3:0]  flags_out;
   logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, resp;
   logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
   logic s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in, busy_out;
   logic s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out;
   logic s_axi_rready_in;
   int   error_cnt = 0;
   int   checks = 0;

   always #50 mclk_in = ~mclk_in;

   amad_datapath u_dut (.mclk_in, .reset_in, .s_axi_awaddr_in,
      .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
      .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
      .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
      .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
      .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
      .s_axi_rready_in, .work_register_out, .flags_out,
      .stack_pointer_out, .busy_out);

   amad_axi_master u_bus (.mclk_in, .awaddr_out(s_axi_awaddr_in),
      .awvalid_out(s_axi_awvalid_in), .wdata_out(s_axi_wdata_in),
      .wvalid_out(s_axi_wvalid_in), .bready_out(s_axi_bready_in),
      .araddr_out(s_axi_araddr_in), .arvalid_out(s_axi_arvalid_in),
      .rready_out(s_axi_rready_in), .awready_in(s_axi_awready_out),
      .wready_in(s_axi_wready_out), .bvalid_in(s_axi_bvalid_out),
      .bresp_in(s_axi_bresp_out), .arready_in(s_axi_arready_out),
      .rvalid_in(s_axi_rvalid_out), .rdata_in(s_axi_rdata_out),
      .rresp_in(s_axi_rresp_out));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      u_bus.wr(a, {24'h000000, d}, resp);
      chk(32'(resp), 32'h00000000);
   endtask
   task automatic rdchk(input logic [7:0] a, e);
      u_bus.rd(a, rdat, resp);
      chk(rdat, {24'h000000, e});
   endtask
   task automatic setmem(input logic [7:0] a, d);
      wr(8'h10, a);
      wr(8'h14, d);
   endtask
   task automatic memchk(input logic [7:0] a, e);
      wr(8'h10, a);
      rdchk(8'h14, e);
   endtask
   task automatic setwf(input logic [7:0] w, input logic [3:0] f);
      wr(8'h04, w);
      wr(8'h08, {4'h0, f});
   endtask
   task automatic cmd(input logic [3:0] op, input logic dst,
                      input logic [7:0] opnd);
      u_bus.wr(8'h00, {16'h0000, opnd, 3'h0, dst, op}, resp);
      @(posedge mclk_in);
   endtask
   // {excess, half, carry, zero, result}; sb picks subtract with borrow
   function automatic [11:0] alu(input logic [7:0] a, b,
                                 input logic ci, sb);
      logic [8:0] s;
      logic [4:0] h;
      logic       v;
      s = sb ? {1'b0, a} - b - ci : {1'b0, a} + b + ci;
      h = sb ? {1'b0, a[3:0]} - b[3:0] - ci : {1'b0, a[3:0]} + b[3:0] + ci;
      v = (sb ? a[7] != b[7] : a[7] == b[7]) && s[7] != a[7];
      return {v, h[4], s[8], s[7:0] == 8'h00, s[7:0]};
   endfunction
   task automatic ar(input logic [3:0] op, input logic dst,
                     input logic [7:0] opnd, w0, input logic [3:0] f0,
                     input logic [7:0] m, input logic [11:0] e);
      setmem(opnd, m);
      setwf(w0, f0);
      cmd(op, dst, opnd);
      chk(32'({flags_out, work_register_out}),
          32'({e[11:8], dst ? w0 : e[7:0]}));
      memchk(opnd, dst ? e[7:0] : m);
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   task automatic t_reset;
      rdchk(8'h04, 8'h00);
      rdchk(8'h08, 8'h00);
      rdchk(8'h0C, 8'h00);
      u_bus.rd(8'h1C, rdat, resp);
      chk(rdat, 32'h00000000);
      chk(32'(resp), 32'h00000002);
      u_bus.wr(8'h1C, 32'h000000FF, resp);
      chk(32'(resp), 32'h00000002);
      s_axi_wstrb_in <= 4'hE;
      wr(8'h04, 8'h77);
      s_axi_wstrb_in <= 4'hF;
      rdchk(8'h04, 8'h00);
      $display("reset test done");
   endtask

   task automatic t_move;
      setmem(8'h20, 8'h5B);
      setmem(8'h21, 8'h00);
      setwf(8'hA5, 4'h6);
      cmd(4'h0, 1'b0, 8'h20);
      chk(32'({flags_out, work_register_out}), 32'h000006A5);
      memchk(8'h5B, 8'hA5);
      setmem(8'h30, 8'h3C);
      cmd(4'h1, 1'b0, 8'h30);
      chk(32'({flags_out, work_register_out}), 32'h0000063C);
      memchk(8'h30, 8'hA5);
      wr(8'h0C, 8'h40);
      setwf(8'h5A, 4'h9);
      cmd(4'h2, 1'b0, 8'h00);
      chk(32'({stack_pointer_out, flags_out}), 32'h00000429);
      memchk(8'h40, 8'h5A);
      memchk(8'h41, 8'h09);
      setwf(8'h00, 4'h0);
      cmd(4'h3, 1'b0, 8'h00);
      chk(32'({stack_pointer_out, flags_out, work_register_out}),
          32'h0004095A);
      cmd(4'hF, 1'b0, 8'h00);
      rdchk(8'h18, 8'h02);
      $display("move test done");
   endtask

   task automatic t_arith;
      ar(4'h4, 1'b0, 8'h0F, 8'h7F, 4'h0, 8'h00,
         alu(8'h7F, 8'h0F, 1'b0, 1'b0));
      ar(4'h4, 1'b0, 8'h01, 8'hFF, 4'h0, 8'h00,
         alu(8'hFF, 8'h01, 1'b0, 1'b0));
      ar(4'h5, 1'b0, 8'h50, 8'h80, 4'h0, 8'h81,
         alu(8'h80, 8'h81, 1'b0, 1'b0));
      ar(4'h5, 1'b1, 8'h50, 8'h12, 4'h0, 8'hF9,
         alu(8'h12, 8'hF9, 1'b0, 1'b0));
      ar(4'h6, 1'b0, 8'h51, 8'h3C, 4'h2, 8'h0C,
         alu(8'h3C, 8'h0C, 1'b1, 1'b0));
      ar(4'h6, 1'b1, 8'h51, 8'hFF, 4'h2, 8'h00,
         alu(8'hFF, 8'h00, 1'b1, 1'b0));
      ar(4'h7, 1'b0, 8'h52, 8'hFF, 4'h2, 8'h11,
         alu(8'hFF, 8'h00, 1'b1, 1'b0));
      ar(4'h7, 1'b1, 8'h52, 8'h11, 4'h2, 8'h7F,
         alu(8'h7F, 8'h00, 1'b1, 1'b0));
      ar(4'h8, 1'b0, 8'h53, 8'h05, 4'h0, 8'h03,
         alu(8'h03, 8'h05, 1'b0, 1'b1));
      ar(4'h8, 1'b1, 8'h53, 8'h80, 4'h0, 8'h01,
         alu(8'h80, 8'h01, 1'b0, 1'b1));
      ar(4'h9, 1'b0, 8'h0F, 8'h05, 4'h0, 8'h00,
         alu(8'h05, 8'h0F, 1'b0, 1'b1));
      ar(4'h9, 1'b0, 8'h0F, 8'h0F, 4'h2, 8'h00,
         alu(8'h0F, 8'h0F, 1'b0, 1'b1));
      ar(4'hA, 1'b0, 8'h54, 8'h90, 4'h0, 8'h10,
         alu(8'h90, 8'h10, 1'b0, 1'b1));
      ar(4'hA, 1'b0, 8'h54, 8'h10, 4'h0, 8'h20,
         alu(8'h10, 8'h20, 1'b0, 1'b1));
      $display("arith test done");
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge mclk_in);
      reset_in <= 1'b0;
      t_reset();
      t_move();
      t_arith();
      stop_test();
   end

   // tests take about 500 cycles; cut off at 20000
   initial begin
      #2000000;
      error_cnt++;
      stop_test();
   end
endmodule // amad_datapath_tb
